// file: logic/plcd_core.sv
// Functional notes
// - Opcode is low nibble of first byte; codes 0..15 in fixed order.
// - Arithmetic opcodes step four bytes, all others step two.
// - Bit ops, set, clear: bit index upper nibble, parameter second byte.
// - Arithmetic operands come from bytes two and three; the result goes to byte four.
// - Terminator ignores its second byte.
// - Input copy bit 4 picks control or option flags word.
// - Input copy bit 5 inverts the copied bit.
// - Input copy bit index is the whole second byte.
// - Input copy at 4 or later, or after another op, is a no-op.
// - Store holds 512 bytes; nothing is placed beyond it.
// - One program only; terminator ends it.
// - Save command bit stores the program persistently.
// - Program byte access only within addresses 0 to 511.
// - Program bytes written with command type 3, address, length, data.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module plcd_core (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire plcd_pkg::plcd_apb_req_t apbReq,
	output var  plcd_pkg::plcd_apb_rsp_t apbRsp,
	output var  logic                    plcRunning,
	output var  logic                    resultBit
);
	import plcd_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0]          progMem  [PROG_BYTES];
	logic [7:0]          savedMem [PROG_BYTES];
	logic [PARAM_DW-1:0] paramMem [PARAM_COUNT];

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_SAVE = 3'b100
	} plcd_state_t;

	plcd_state_t          state;
	plcd_state_t          next_state;
	logic [PROG_AW-1:0]   pc;
	logic [PROG_AW-1:0]   next_pc;
	logic [PROG_AW-1:0]   saveIdx;
	logic                 acc;
	logic                 next_acc;
	logic                 copyOk;
	logic                 next_copyOk;
	logic                 runEnable;
	logic                 saveReq;
	logic                 savedFlag;
	logic                 accessErr;
	logic                 scanErr;
	logic [31:0]          progData;
	logic [FLAG_DW-1:0]   ctrlFlags;
	logic [FLAG_DW-1:0]   optFlags;
	logic [7:0]           paramAddr;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic setupPhase = apbReq.psel & ~apbReq.penable;
	wire logic accessDone = apbReq.psel & apbReq.penable & apbRsp.pready;
	wire logic wrDone     = accessDone & apbReq.pwrite;
	wire logic [7:0] addr = apbReq.paddr;
	wire logic [31:0] wdat = apbReq.pwdata;

	wire logic selCtrl   = (addr == REG_CTRL);
	wire logic selStatus = (addr == REG_STATUS);
	wire logic selCmd    = (addr == REG_PROG_CMD);
	wire logic selData   = (addr == REG_PROG_DATA);
	wire logic selCflg   = (addr == REG_CTRL_FLAGS);
	wire logic selOflg   = (addr == REG_OPT_FLAGS);
	wire logic selPaddr  = (addr == REG_PARAM_ADDR);
	wire logic selPdata  = (addr == REG_PARAM_DATA);
	wire logic mapped    = selCtrl | selStatus | selCmd | selData |
		selCflg | selOflg | selPaddr | selPdata;

	// Program access command fields
	wire logic [PROG_AW-1:0] cmdAddr = wdat[PCMD_ADDR_LSB +: PROG_AW];
	wire logic [2:0] cmdLen  = wdat[PCMD_LEN_LSB +: 3];
	wire logic [2:0] cmdType = wdat[PCMD_TYPE_LSB +: 3];
	wire logic [9:0] cmdEnd  = {1'b0, cmdAddr} + {7'h00, cmdLen};
	wire logic cmdIsWrite = (cmdType == CMD_WRITE_INSTR);
	wire logic cmdIsRead  = (cmdType == CMD_READ_INSTR);
	wire logic cmdInRange = (cmdEnd <= PROG_END_ADDR);
	wire logic cmdLenOk   = (cmdLen >= LEN_MIN) && (cmdLen <= LEN_MAX);
	wire logic cmdOk = (cmdIsWrite | cmdIsRead) & cmdInRange & cmdLenOk;
	wire logic cmdBad = apbReq.pwrite & selCmd & ~cmdOk;

	wire logic cmdWrite = wrDone & selCmd & cmdOk & cmdIsWrite;
	wire logic cmdRead  = wrDone & selCmd & cmdOk & cmdIsRead;
	wire logic saveCmd  = wrDone & selCtrl & wdat[CTRL_SAVE_BIT];
	wire logic paramApbWr = wrDone & selPdata;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] statusWord;
	logic [31:0] readWord;

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[STAT_RUN_BIT]     = (state == ST_RUN);
		statusWord[STAT_SAVING_BIT]  = (state == ST_SAVE);
		statusWord[STAT_SAVED_BIT]   = savedFlag;
		statusWord[STAT_ACCERR_BIT]  = accessErr;
		statusWord[STAT_SCANERR_BIT] = scanErr;
		statusWord[STAT_RESULT_BIT]  = acc;
		statusWord[STAT_PC_LSB +: PROG_AW] = pc;
	end

	always_comb begin
		readWord = 32'h0000_0000;
		if (selCtrl)
			readWord[CTRL_RUN_BIT] = runEnable;
		else if (selStatus)
			readWord = statusWord;
		else if (selData)
			readWord = progData;
		else if (selCflg)
			readWord[FLAG_DW-1:0] = ctrlFlags;
		else if (selOflg)
			readWord[FLAG_DW-1:0] = optFlags;
		else if (selPaddr)
			readWord[7:0] = paramAddr;
		else if (selPdata)
			readWord[PARAM_DW-1:0] = paramMem[paramAddr];
	end

	// Answer one cycle after setup: a fixed single access cycle.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			apbRsp <= '0;
		end else begin
			apbRsp.pready  <= setupPhase;
			apbRsp.pslverr <= setupPhase & (~mapped | cmdBad);
			if (setupPhase)
				apbRsp.prdata <= apbReq.pwrite ? 32'h0000_0000 : readWord;
		end
	end

	// ----------------------------------------------------------------
	// Instruction fetch and decode
	// ----------------------------------------------------------------
	plcd_instr_t        dec;
	logic [15:0]        arithRes;
	wire logic [PROG_AW-1:0] pc1 = pc + 9'h001;
	wire logic [PROG_AW-1:0] pc2 = pc + 9'h002;
	wire logic [PROG_AW-1:0] pc3 = pc + 9'h003;
	wire logic [31:0] fetchWord = {progMem[pc3], progMem[pc2],
		progMem[pc1], progMem[pc]};

	plcd_instr_decode u_decode (
		.instrBytes (fetchWord),
		.instr      (dec)
	);

	wire logic [PARAM_DW-1:0] opA = paramMem[dec.paramA];
	wire logic [PARAM_DW-1:0] opB = paramMem[dec.paramB];
	wire logic operandBit = opA[dec.bitIdx];
	wire logic [FLAG_DW-1:0] srcWord = dec.srcOption ? optFlags : ctrlFlags;
	wire logic srcInRange = (dec.copyIdx < 8'(FLAG_DW));
	wire logic srcBit = srcInRange & srcWord[dec.copyIdx[3:0]];
	wire logic [9:0] stepAddr = {1'b0, pc} + {7'h00, dec.len};

	plcd_arith u_arith (
		.opcode (dec.opcode),
		.opA    (opA),
		.opB    (opB),
		.result (arithRes)
	);

	// ----------------------------------------------------------------
	// Execution
	// ----------------------------------------------------------------
	// Bus writes to the parameter file win; the scan waits a cycle.
	wire logic execStep = (state == ST_RUN) & ~paramApbWr;

	logic                exWe;
	logic [7:0]          exAddr;
	logic [PARAM_DW-1:0] exData;
	logic                scanErrSet;

	always_comb begin
		next_acc    = acc;
		next_pc     = pc;
		next_copyOk = copyOk;
		exWe        = 1'b0;
		exAddr      = dec.paramA;
		exData      = opA;
		scanErrSet  = 1'b0;
		unique case (dec.opcode)
			OP_LOAD_BIT:           next_acc = operandBit;
			OP_LOAD_BIT_INVERTED:  next_acc = ~operandBit;
			OP_CONJUNCT:           next_acc = acc & operandBit;
			OP_CONJUNCT_INVERTED:  next_acc = acc & ~operandBit;
			OP_DISJUNCT:           next_acc = acc | operandBit;
			OP_DISJUNCT_INVERTED:  next_acc = acc | ~operandBit;
			OP_STORE_BIT: begin
				exWe = 1'b1;
				exData[dec.bitIdx] = acc;
			end
			OP_STORE_BIT_INVERTED: begin
				exWe = 1'b1;
				exData[dec.bitIdx] = ~acc;
			end
			OP_SET_BIT: begin
				exWe = acc;
				exData[dec.bitIdx] = 1'b1;
			end
			OP_CLEAR_BIT: begin
				exWe = acc;
				exData[dec.bitIdx] = 1'b0;
			end
			OP_ADD, OP_SUBTRACT, OP_PRODUCT, OP_DIVIDE: begin
				exWe   = 1'b1;
				exAddr = dec.paramC;
				exData = arithRes;
			end
			OP_INPUT_COPY: begin
				if (copyOk)
					next_acc = srcBit ^ dec.invert;
			end
			OP_TERMINATOR: ; // Second byte unused
		endcase
		if (dec.opcode == OP_TERMINATOR) begin
			next_pc     = '0;
			next_copyOk = 1'b1;
		end else if (stepAddr >= PROG_END_ADDR) begin
			// Ran off the store without a terminator
			next_pc     = '0;
			next_copyOk = 1'b1;
			scanErrSet  = 1'b1;
		end else begin
			next_pc     = stepAddr[PROG_AW-1:0];
			next_copyOk = copyOk & (dec.opcode == OP_INPUT_COPY) &
				(stepAddr < COPY_AREA_END);
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wire logic saveLast = (saveIdx == 9'(PROG_BYTES - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (saveReq)
					next_state = ST_SAVE;
				else if (runEnable)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (saveReq)
					next_state = ST_SAVE;
				else if (!runEnable)
					next_state = ST_IDLE;
			end
			ST_SAVE: begin
				if (saveLast)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			saveIdx <= '0;
		end else begin
			state   <= next_state;
			saveIdx <= (state == ST_SAVE) ? saveIdx + 9'h001 : '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc     <= '0;
			acc    <= 1'b0;
			copyOk <= 1'b1;
		end else if (execStep) begin
			pc     <= next_pc;
			acc    <= next_acc;
			copyOk <= next_copyOk;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	wire logic clrAccErr  = wrDone & selStatus & wdat[STAT_ACCERR_BIT];
	wire logic clrScanErr = wrDone & selStatus & wdat[STAT_SCANERR_BIT];
	wire logic accErrSet  = accessDone & apbRsp.pslverr;
	wire logic saveDone   = (state == ST_SAVE) & saveLast;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			runEnable <= 1'b0;
			saveReq   <= 1'b0;
			savedFlag <= 1'b0;
			accessErr <= 1'b0;
			scanErr   <= 1'b0;
			ctrlFlags <= '0;
			optFlags  <= '0;
			paramAddr <= '0;
		end else begin
			if (wrDone & selCtrl)
				runEnable <= wdat[CTRL_RUN_BIT];
			// Request held until the copy actually starts
			if (saveCmd)
				saveReq <= 1'b1;
			else if (state == ST_SAVE)
				saveReq <= 1'b0;
			if (saveDone)
				savedFlag <= 1'b1;
			else if (saveCmd)
				savedFlag <= 1'b0;
			// Hardware set wins over software clear
			accessErr <= accErrSet | (accessErr & ~clrAccErr);
			scanErr <= (execStep & scanErrSet) | (scanErr & ~clrScanErr);
			if (wrDone & selCflg)
				ctrlFlags <= wdat[FLAG_DW-1:0];
			if (wrDone & selOflg)
				optFlags <= wdat[FLAG_DW-1:0];
			if (wrDone & selPaddr)
				paramAddr <= wdat[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Program store access
	// ----------------------------------------------------------------
	// Bytes go to addr, addr+1, ... from the data word's low byte up.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			progData <= '0;
		end else if (cmdRead) begin
			for (int i = 0; i < 4; i++)
				progData[8*i +: 8] <= (3'(i) < cmdLen) ?
					progMem[cmdAddr + 9'(i)] : 8'h00;
		end else if (wrDone & selData) begin
			progData <= wdat;
		end
	end

	// Memories carry no reset; contents survive a reset.
	logic [PROG_AW-1:0] laneAddr [4];
	logic [3:0]         laneWe;

	generate
		for (genvar b = 0; b < 4; b++) begin : g_progLane
			assign laneAddr[b] = cmdAddr + 9'(b);
			assign laneWe[b]   = cmdWrite & (3'(b) < cmdLen);
		end
	endgenerate

	// One writer process for the store; lanes never share a byte
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (laneWe[i])
				progMem[laneAddr[i]] <= progData[8*i +: 8];
		end
	end

	// Persistent copy, one byte per clock
	always_ff @(posedge core_clk) begin
		if (state == ST_SAVE)
			savedMem[saveIdx] <= progMem[saveIdx];
	end

	// ----------------------------------------------------------------
	// Parameter file
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (paramApbWr)
			paramMem[paramAddr] <= wdat[PARAM_DW-1:0];
		else if (execStep & exWe)
			paramMem[exAddr] <= exData;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			plcRunning <= 1'b0;
			resultBit  <= 1'b0;
		end else begin
			plcRunning <= (next_state == ST_RUN);
			resultBit  <= execStep ? next_acc : acc;
		end
	end

endmodule : plcd_core
`default_nettype wire

// file: logic/plcd_pkg.sv
`default_nettype none
package plcd_pkg;

	// ----------------------------------------------------------------
	// Store geometry
	// ----------------------------------------------------------------
	localparam int unsigned PROG_BYTES  = 512;
	localparam int unsigned PROG_AW     = 9;
	localparam int unsigned PARAM_COUNT = 256;
	localparam int unsigned PARAM_DW    = 16;
	localparam int unsigned FLAG_DW     = 16;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_PROG_CMD   = 8'h08;
	localparam logic [7:0] REG_PROG_DATA  = 8'h0c;
	localparam logic [7:0] REG_CTRL_FLAGS = 8'h10;
	localparam logic [7:0] REG_OPT_FLAGS  = 8'h14;
	localparam logic [7:0] REG_PARAM_ADDR = 8'h18;
	localparam logic [7:0] REG_PARAM_DATA = 8'h1c;

	// Field positions
	localparam int unsigned CTRL_RUN_BIT    = 0;
	localparam int unsigned CTRL_SAVE_BIT   = 1;
	localparam int unsigned STAT_RUN_BIT    = 0;
	localparam int unsigned STAT_SAVING_BIT = 1;
	localparam int unsigned STAT_SAVED_BIT  = 2;
	localparam int unsigned STAT_ACCERR_BIT = 3;
	localparam int unsigned STAT_SCANERR_BIT = 4;
	localparam int unsigned STAT_RESULT_BIT = 5;
	localparam int unsigned STAT_PC_LSB     = 16;
	localparam int unsigned PCMD_ADDR_LSB   = 0;
	localparam int unsigned PCMD_LEN_LSB    = 16;
	localparam int unsigned PCMD_TYPE_LSB   = 21;

	// ----------------------------------------------------------------
	// Serial command types and instruction layout
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_READ_INSTR  = 3'h2;
	localparam logic [2:0] CMD_WRITE_INSTR = 3'h3;
	localparam logic [2:0] LEN_MIN         = 3'h1;
	localparam logic [2:0] LEN_MAX         = 3'h4;
	localparam logic [2:0] LEN_SHORT       = 3'h2;
	localparam logic [2:0] LEN_LONG        = 3'h4;
	localparam logic [9:0] PROG_END_ADDR   = 10'h200;
	localparam logic [9:0] COPY_AREA_END   = 10'h004;
	localparam logic [15:0] DIV_ZERO_RESULT = 16'hffff;

	typedef enum logic [3:0] {
		OP_LOAD_BIT          = 4'h0,
		OP_LOAD_BIT_INVERTED = 4'h1,
		OP_STORE_BIT         = 4'h2,
		OP_STORE_BIT_INVERTED = 4'h3,
		OP_CONJUNCT          = 4'h4,
		OP_CONJUNCT_INVERTED = 4'h5,
		OP_DISJUNCT          = 4'h6,
		OP_DISJUNCT_INVERTED = 4'h7,
		OP_ADD               = 4'h8,
		OP_SUBTRACT          = 4'h9,
		OP_PRODUCT           = 4'ha,
		OP_DIVIDE            = 4'hb,
		OP_SET_BIT           = 4'hc,
		OP_CLEAR_BIT         = 4'hd,
		OP_INPUT_COPY        = 4'he,
		OP_TERMINATOR        = 4'hf
	} plcd_opcode_t;

	typedef struct packed {
		plcd_opcode_t opcode;
		logic [2:0]   len;
		logic [3:0]   bitIdx;
		logic [7:0]   paramA;
		logic [7:0]   paramB;
		logic [7:0]   paramC;
		logic         srcOption;
		logic         invert;
		logic [7:0]   copyIdx;
	} plcd_instr_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} plcd_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} plcd_apb_rsp_t;

endpackage : plcd_pkg
`default_nettype wire

// file: logic/plcd_instr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module plcd_instr_decode (
	input  wire logic [31:0]         instrBytes,
	output var  plcd_pkg::plcd_instr_t instr
);
	import plcd_pkg::*;

	wire logic [7:0] firstByte = instrBytes[7:0];
	wire plcd_opcode_t opcode  = plcd_opcode_t'(firstByte[3:0]);
	wire logic isArith = (opcode == OP_ADD) || (opcode == OP_SUBTRACT) ||
		(opcode == OP_PRODUCT) || (opcode == OP_DIVIDE);

	always_comb begin
		instr.opcode    = opcode;
		instr.len       = isArith ? LEN_LONG : LEN_SHORT;
		instr.bitIdx    = firstByte[7:4];
		instr.paramA    = instrBytes[15:8];
		instr.paramB    = instrBytes[23:16];
		instr.paramC    = instrBytes[31:24];
		instr.srcOption = firstByte[4];
		instr.invert    = firstByte[5];
		instr.copyIdx   = instrBytes[15:8];
	end

endmodule : plcd_instr_decode
`default_nettype wire

// file: logic/plcd_arith.sv
`timescale 1ns/1ns
`default_nettype none
module plcd_arith (
	input  wire plcd_pkg::plcd_opcode_t opcode,
	input  wire logic [15:0]            opA,
	input  wire logic [15:0]            opB,
	output var  logic [15:0]            result
);
	import plcd_pkg::*;

	wire logic [31:0] product  = opA * opB;
	wire logic        divZero  = (opB == 16'h0000);
	wire logic [15:0] quotient = divZero ? DIV_ZERO_RESULT : opA / opB;

	// Products keep the low half; wrap-around matches the add and sub.
	always_comb begin
		unique case (opcode)
			OP_ADD:      result = opA + opB;
			OP_SUBTRACT: result = opA - opB;
			OP_PRODUCT:  result = product[15:0];
			default:     result = quotient;
		endcase
	end

endmodule : plcd_arith
`default_nettype wire

// file: verif/plcd_core_props.sv
`timescale 1ns/1ns
`default_nettype none
module plcd_core_props (
	input wire logic                    core_clk,
	input wire logic                    rst_n,
	input wire plcd_pkg::plcd_apb_req_t apbReq,
	input wire plcd_pkg::plcd_apb_rsp_t apbRsp,
	input wire logic                    plcRunning,
	input wire logic                    resultBit
);
	import plcd_pkg::*;
	// ----------------------------------------------------------------
	// Bus decode helpers
	// ----------------------------------------------------------------
	wire logic       setup = apbReq.psel & ~apbReq.penable;
	wire logic       acc   = apbReq.psel & apbReq.penable & apbRsp.pready;
	wire logic [2:0] cmdTy = apbReq.pwdata[23:21];
	wire logic [2:0] cmdLn = apbReq.pwdata[18:16];
	wire logic [9:0] cmdEnd = {1'b0, apbReq.pwdata[8:0]} + {7'h00, cmdLn};
	wire logic       cmdWr = setup & apbReq.pwrite
		& (apbReq.paddr == REG_PROG_CMD);
	wire logic       tyOk = (cmdTy == CMD_READ_INSTR)
		| (cmdTy == CMD_WRITE_INSTR);
	wire logic       lnOk = (cmdLn >= LEN_MIN) & (cmdLn <= LEN_MAX);
	wire logic       ctrlWr = acc & apbReq.pwrite & (apbReq.paddr == REG_CTRL);

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	ready_after_setup_a: assert property (setup |=> apbRsp.pready)
		else $error("no ready after setup");
	ready_needs_setup_a: assert property (apbRsp.pready |-> $past(setup))
		else $error("ready without setup");
	ready_one_cycle_a: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (
		setup && apbReq.paddr > REG_PARAM_DATA
		|=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
		else $error("unmapped access not refused");
	cmd_range_err_a: assert property (
		cmdWr && tyOk && lnOk && cmdEnd > PROG_END_ADDR |=> apbRsp.pslverr)
		else $error("program access past end accepted");
	cmd_type_err_a: assert property (
		cmdWr && !tyOk |=> apbRsp.pslverr)
		else $error("bad command type accepted");
	cmd_ok_a: assert property (
		cmdWr && tyOk && lnOk && cmdEnd <= PROG_END_ADDR |=> !apbRsp.pslverr)
		else $error("legal program command refused");
	stop_scan_a: assert property (
		ctrlWr && apbReq.pwdata[1:0] == 2'h0 |-> ##[1:3] !plcRunning)
		else $error("scan did not stop");
	save_pause_a: assert property (
		ctrlWr && apbReq.pwdata[1] |-> ##[1:2] (!plcRunning [*8]))
		else $error("scan not paused by save");
	result_hold_a: assert property (
		!$past(plcRunning) |-> $stable(resultBit))
		else $error("result bit moved while idle");
endmodule : plcd_core_props

bind plcd_core plcd_core_props u_plcd_core_props (
	.core_clk  (core_clk),
	.rst_n     (rst_n),
	.apbReq    (apbReq),
	.apbRsp    (apbRsp),
	.plcRunning(plcRunning),
	.resultBit (resultBit)
);
`default_nettype wire

// file: verif/plcd_host.sv
`timescale 1ns/1ns
`default_nettype none
module plcd_host (
	input  wire logic                    core_clk,
	input  wire plcd_pkg::plcd_apb_rsp_t apbRsp,
	output var  plcd_pkg::plcd_apb_req_t apbReq
);
	import plcd_pkg::*;
	logic [31:0] rdata;
	logic        rerr;
	initial apbReq = '0;

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		apbReq.psel <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite <= w;
		apbReq.paddr <= a;
		apbReq.pwdata <= d;
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		// Waits as long as needed; only the bench watchdog ends a hang
		do begin
			@(posedge core_clk);
		end while (apbRsp.pready !== 1'b1);
		rdata = apbRsp.prdata;
		rerr = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		// Released data lines must not look valid
		apbReq.pwdata <= ~d;
	endtask : xfer

	// Bytes go to the data word first, then the write command
	task automatic prog(input logic [8:0] a, input logic [2:0] ln,
		input logic [31:0] d);
		xfer(1'b1, REG_PROG_DATA, d);
		xfer(1'b1, REG_PROG_CMD,
			{8'h00, CMD_WRITE_INSTR, 2'h0, ln, 7'h00, a});
	endtask : prog

	task automatic setp(input logic [7:0] i, input logic [15:0] v);
		xfer(1'b1, REG_PARAM_ADDR, {24'h0, i});
		xfer(1'b1, REG_PARAM_DATA, {16'h0, v});
	endtask : setp

	task automatic getp(input logic [7:0] i);
		xfer(1'b1, REG_PARAM_ADDR, {24'h0, i});
		xfer(1'b0, REG_PARAM_DATA, 32'h0);
	endtask : getp
endmodule : plcd_host
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import plcd_pkg::*;
	logic          core_clk = 1'b0;
	logic          rst_n = 1'b0;
	plcd_apb_req_t apbReq;
	plcd_apb_rsp_t apbRsp;
	logic          plcRunning;
	logic          resultBit;
	int            badCount = 0;
	int            nTests = 0;
	logic [15:0]   arithExp [4] = '{16'h0011, 16'h000b, 16'h002a, 16'h0004};

	always #25 core_clk = ~core_clk;

	plcd_core u_plcd_core (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq),
		.apbRsp(apbRsp), .plcRunning(plcRunning), .resultBit(resultBit));
	plcd_host u_plcd_host (.core_clk(core_clk), .apbRsp(apbRsp), .apbReq(apbReq));

	task automatic testDone;
		if (badCount == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : testDone

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Short scan burst; one instruction per clock, so 12 cycles is ample
	task automatic runScan;
		u_plcd_host.xfer(1'b1, REG_CTRL, 32'h1);
		repeat (12) @(posedge core_clk);
		u_plcd_host.xfer(1'b1, REG_CTRL, 32'h0);
	endtask : runScan

	task automatic tAccess;
		u_plcd_host.xfer(1'b0, REG_STATUS, 32'h0);
		chk(u_plcd_host.rdata, 32'h0);
		u_plcd_host.prog(9'h1fc, 3'h4, 32'ha55a_c33c);
		chk({31'h0, u_plcd_host.rerr}, 32'h0);
		u_plcd_host.xfer(1'b1, REG_PROG_CMD,
			{8'h00, CMD_READ_INSTR, 2'h0, 3'h4, 16'h01fc});
		u_plcd_host.xfer(1'b0, REG_PROG_DATA, 32'h0);
		chk(u_plcd_host.rdata, 32'ha55a_c33c);
		u_plcd_host.prog(9'h1fd, 3'h4, 32'h0);
		chk({31'h0, u_plcd_host.rerr}, 32'h1);
		u_plcd_host.xfer(1'b1, REG_PROG_CMD,
			{8'h00, 3'h5, 2'h0, 3'h2, 16'h0000});
		chk({31'h0, u_plcd_host.rerr}, 32'h1);
		u_plcd_host.xfer(1'b0, 8'h20, 32'h0);
		chk({u_plcd_host.rdata[30:0], u_plcd_host.rerr}, 32'h1);
	endtask : tAccess

	task automatic tCopy;
		u_plcd_host.xfer(1'b1, REG_CTRL_FLAGS, 32'h0008);
		u_plcd_host.xfer(1'b1, REG_OPT_FLAGS, 32'h0000);
		u_plcd_host.setp(8'h00, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			u_plcd_host.prog(9'h000, 3'h4,
				{16'h000f, 8'h03, 2'h0, i[1:0], 4'he});
			runScan();
			chk({31'h0, resultBit}, {31'h0, ~i[0] ^ i[1]});
		end
		// Copy placed after other instructions must do nothing
		u_plcd_host.prog(9'h000, 3'h4, 32'h0);
		u_plcd_host.prog(9'h004, 3'h4, {16'h000f, 16'h030e});
		runScan();
		chk({31'h0, resultBit}, 32'h0);
	endtask : tCopy

	task automatic tArith;
		u_plcd_host.setp(8'h01, 16'h000e);
		u_plcd_host.setp(8'h02, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			u_plcd_host.prog(9'h000, 3'h4,
				{24'h030201, 4'h0, 4'h8 + i[3:0]});
			u_plcd_host.prog(9'h004, 3'h2, 32'h0000_000f);
			runScan();
			u_plcd_host.getp(8'h03);
			chk(u_plcd_host.rdata, {16'h0, arithExp[i]});
		end
	endtask : tArith

	task automatic tBits;
		u_plcd_host.setp(8'h04, 16'h0000);
		u_plcd_host.setp(8'h05, 16'h0000);
		u_plcd_host.prog(9'h000, 3'h4, 32'h0422_0001);
		// Junk in the terminator's second byte must not matter
		u_plcd_host.prog(9'h004, 3'h4, 32'h5a0f_05fc);
		runScan();
		u_plcd_host.getp(8'h04);
		chk(u_plcd_host.rdata, 32'h0004);
		u_plcd_host.getp(8'h05);
		chk(u_plcd_host.rdata, 32'h8000);
	endtask : tBits

	task automatic tSave;
		int n;
		u_plcd_host.xfer(1'b1, REG_CTRL, 32'h2);
		n = 0;
		do begin
			u_plcd_host.xfer(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (u_plcd_host.rdata[STAT_SAVED_BIT] !== 1'b1 && n < 300);
		chk({29'h0, u_plcd_host.rdata[2:0]}, 32'h4);
	endtask : tSave

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		tAccess();
		tCopy();
		tArith();
		tBits();
		tSave();
		testDone();
	end

	initial begin
		repeat (30000) @(posedge core_clk);
		badCount++;
		testDone();
	end
endmodule : tb
`default_nettype wire
